// [include/fault_level_defines.vh]
// Constants for the fault-code level indicator on the actual-value output.
// Notes on behaviour
// - While an alarm is present and reset is not held, output shows a fault level, not temperature.
// - Twelve fault levels exist in the 0 to 10 V range, some shared by two code groups.
// - Calibration and configuration faults alternate at 1 Hz with full scale.
// - Start during alternation stops it and holds the fault level.
// - A latched alarm clears only by reset input or power cycle.
// - Reset clears the alarm only when the reset input is released.
// - The exact internal error code stays readable for diagnostics.
// - Codes 101, 102, 103 give 0.66, 1.33 and 2.00 volts.
// - Code 304 gives 4.00 volts.
// - Codes 901 and 913 to 916 give 4.66 volts.
// - Listed faults start as warnings; start turns them into alarm-high faults.
// - After reset release, a 500 ms initialisation refuses a new start.
`ifndef FAULT_LEVEL_DEFINES_VH
`define FAULT_LEVEL_DEFINES_VH

`define CLK_FREQ_HZ       100000000
`define HALF_PERIOD_MS    500
`define INIT_TIME_MS      500
// Both spans are 500 ms of the 100 MHz clock, sized to the counter width.
`define HALF_PERIOD_CYC   26'h2fa_f080
`define HALF_LAST_CYC     26'h2fa_f07f
`define INIT_CYC          26'h2fa_f080
`define CNT_ONE           26'h000_0001
`define CNT_W             26

// Output code is a 10-bit DAC word, 0x3FF being 10 V full scale.
`define DAC_W             10
`define DAC_FULL          10'h3ff
`define DAC_ZERO          10'h000
// Level n of 15 steps: n * 1023 / 15 (0.66 V per step).
`define LVL_STEP(n)       (((n) * 1023) / 15)

// Error codes held as 10-bit decimal numbers.
`define CODE_W            10
`define CODE_NONE         10'h000

`endif

// [src/fault_code_mapper.v]
// Maps an internal error code to its output level and indication class.
`timescale 1ns/1ps
`default_nettype none
`include "fault_level_defines.vh"

module fault_code_mapper (
    input  wire [`CODE_W-1:0] code_in,
    output reg  [`DAC_W-1:0]  level_out,
    output reg                alternate_out,
    output reg                warning_out
);
    reg [3:0]  step;
    reg [31:0] lvl_wide;

    always @* begin
        lvl_wide      = 32'h0000_0000;
        step          = 4'h0;
        alternate_out = 1'b0;
        warning_out   = 1'b0;
        case (code_in)
            10'd101: step = 4'h1;
            10'd102: step = 4'h2;
            10'd103: step = 4'h3;
            10'd107, 10'd108, 10'd307, 10'd308, 10'd309, 10'd310: step = 4'h4;
            10'd201, 10'd202, 10'd203: step = 4'h5;
            10'd304: step = 4'h6;
            10'd901, 10'd913, 10'd914, 10'd915, 10'd916: step = 4'h7;
            10'd917, 10'd918: step = 4'h7;
            10'd104, 10'd105, 10'd106, 10'd211, 10'd302, 10'd303: begin
                step          = 4'h8;
                alternate_out = 1'b1;
                warning_out   = 1'b1;
            end
            10'd110: begin
                step        = 4'h9;
                warning_out = 1'b1;
            end
            10'd111, 10'd112, 10'd113, 10'd114: begin
                // One level each, counting up from the configuration-fault step.
                step          = (code_in == 10'd111) ? 4'h9 :
                                (code_in == 10'd112) ? 4'ha :
                                (code_in == 10'd113) ? 4'hb : 4'hc;
                alternate_out = 1'b1;
                warning_out   = 1'b1;
            end
            default: step = 4'h0;
        endcase
        lvl_wide  = `LVL_STEP(step);
        level_out = lvl_wide[`DAC_W-1:0];
    end
endmodule // fault_code_mapper
`default_nettype wire

// [src/fault_code_level_indicator.v]
// Drives the actual-value output with temperature or a coded fault level.
`timescale 1ns/1ps
`default_nettype none
`include "fault_level_defines.vh"

module fault_code_level_indicator (
    input  wire               clk_in,
    input  wire               reset_n_in,
    input  wire               clk_en_in,
    input  wire [`DAC_W-1:0]  temp_level_in,
    input  wire               fault_valid_in,
    input  wire [`CODE_W-1:0] fault_code_in,
    input  wire               start_in,
    input  wire               reset_ctl_in,
    output reg  [`DAC_W-1:0]  actual_out,
    output reg                alarm_out,
    output reg                start_ok_out,
    output reg                busy_init_out,
    output reg  [`CODE_W-1:0] diag_code_out
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_WARN = 3'b010;
    localparam [2:0] ST_HOLD = 3'b100;

    reg [2:0]         state_reg;
    reg [2:0]         state_next;
    reg [`CODE_W-1:0] code_reg;
    reg [`CNT_W-1:0]  half_cnt_reg;
    reg               phase_reg;
    reg [`CNT_W-1:0]  init_cnt_reg;
    reg               rst_ctl_d_reg;

    wire [`DAC_W-1:0] code_level;
    wire              code_alt;
    wire              code_warn;
    wire              release_pulse;

    fault_code_mapper u_mapper (
        .code_in       (code_reg),
        .level_out     (code_level),
        .alternate_out (code_alt),
        .warning_out   (code_warn)
    );

    // Clearing acts on the falling edge of the reset control, not its level.
    assign release_pulse = rst_ctl_d_reg & ~reset_ctl_in;

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (fault_valid_in && !reset_ctl_in && fault_code_in != `CODE_NONE) begin
                    state_next = ST_WARN;
                end
            end
            ST_WARN: begin
                if (release_pulse) begin
                    state_next = ST_IDLE;
                end else if (start_in || !code_warn) begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (release_pulse) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // Next-value terms for the register blocks below. Each register has a
    // block of its own; all of them share the synchronous reset and the
    // clock enable, so a low enable freezes every piece of state at once.
    wire              enter_warn;
    wire              go_idle;
    wire              half_end;
    wire              show_full;
    wire              init_running;
    wire              start_allowed;
    wire [`CNT_W-1:0] half_cnt_next;
    wire [`CNT_W-1:0] init_cnt_next;

    assign enter_warn = (state_reg == ST_IDLE) && (state_next == ST_WARN);
    assign go_idle    = (state_next == ST_IDLE);

    // The half-period counter only runs while a warning is shown; any other
    // state parks it at zero, so a new warning always opens on the fault level.
    assign half_end      = (half_cnt_reg == `HALF_LAST_CYC);
    assign half_cnt_next = (state_reg != ST_WARN || half_end) ? {`CNT_W{1'b0}}
                         : half_cnt_reg + `CNT_ONE;

    // Full scale is judged on the next state, so the edge on which start
    // freezes the display already shows the fault level and never full scale.
    assign show_full = (state_next == ST_WARN) && code_alt && phase_reg;

    // The init span restarts on every release, even one with no alarm pending.
    // A user must wait it out before a start is honoured again.
    assign init_cnt_next = release_pulse ? `INIT_CYC
                         : (init_cnt_reg != {`CNT_W{1'b0}}) ? init_cnt_reg - `CNT_ONE
                         : init_cnt_reg;
    assign init_running  = (init_cnt_reg > `CNT_ONE);

    // Start is refused while reset is held, initialising, or a warning or alarm is pending.
    assign start_allowed = !reset_ctl_in && !release_pulse && !init_running && go_idle;

    // Delayed copy of the reset control; its reset value matches the idle level
    // of the input, so leaving power-on reset never looks like a release.
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            rst_ctl_d_reg <= 1'b0;
        end else if (clk_en_in) begin
            rst_ctl_d_reg <= reset_ctl_in;
        end
    end

    // Only a release of the reset control or power-on reset leaves an alarm.
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            state_reg <= ST_IDLE;
        end else if (clk_en_in) begin
            state_reg <= state_next;
        end
    end

    // The first fault code is latched; later ones cannot overwrite it.
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            code_reg <= `CODE_NONE;
        end else if (clk_en_in) begin
            if (enter_warn) begin
                code_reg <= fault_code_in;
            end else if (go_idle) begin
                code_reg <= `CODE_NONE;
            end
        end
    end

    // The fine code stays visible for diagnostics while the level is coarse.
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            diag_code_out <= `CODE_NONE;
        end else if (clk_en_in) begin
            diag_code_out <= go_idle ? `CODE_NONE : code_reg;
        end
    end

    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            half_cnt_reg <= {`CNT_W{1'b0}};
        end else if (clk_en_in) begin
            half_cnt_reg <= half_cnt_next;
        end
    end

    // Phase low shows the fault level, phase high shows full scale for alternating codes.
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            phase_reg <= 1'b0;
        end else if (clk_en_in) begin
            if (state_reg != ST_WARN) begin
                phase_reg <= 1'b0;
            end else if (half_end) begin
                phase_reg <= ~phase_reg;
            end
        end
    end

    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            init_cnt_reg <= {`CNT_W{1'b0}};
        end else if (clk_en_in) begin
            init_cnt_reg <= init_cnt_next;
        end
    end

    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            busy_init_out <= 1'b0;
        end else if (clk_en_in) begin
            busy_init_out <= release_pulse || init_running;
        end
    end

    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            start_ok_out <= 1'b0;
        end else if (clk_en_in) begin
            start_ok_out <= start_allowed;
        end
    end

    // Warnings keep the alarm output low until start turns them into faults.
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            alarm_out <= 1'b0;
        end else if (clk_en_in) begin
            alarm_out <= (state_next == ST_HOLD);
        end
    end

    // Near zero while reset is held gives the outside controller feedback that
    // the clear request was seen; it costs the fault level for that time.
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            actual_out <= `DAC_ZERO;
        end else if (clk_en_in) begin
            if (reset_ctl_in) begin
                actual_out <= `DAC_ZERO;
            end else if (show_full) begin
                actual_out <= `DAC_FULL;
            end else if (state_reg != ST_IDLE) begin
                actual_out <= code_level;
            end else begin
                actual_out <= temp_level_in;
            end
        end
    end
endmodule // fault_code_level_indicator
`default_nettype wire

// [dv/fault_level_props.sv]
// Port assertions for the fault-level indicator.
`timescale 1ns/1ps
`default_nettype none
module fault_level_props (
    input wire       clk_in,
    input wire       reset_n_in,
    input wire       reset_ctl_in,
    input wire [9:0] actual_out,
    input wire       alarm_out,
    input wire       start_ok_out,
    input wire       busy_init_out,
    input wire [9:0] diag_code_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    property p_clear; reset_ctl_in [*2] |-> actual_out == 10'h000; endproperty
    a_clear: assert property (p_clear) else $error("clear level");
    property p_hold; alarm_out && !reset_ctl_in && !$past(reset_ctl_in) |=> alarm_out; endproperty
    a_hold: assert property (p_hold) else $error("alarm lost");
    property p_init; busy_init_out |-> !start_ok_out; endproperty
    a_init: assert property (p_init) else $error("start during init");
    property p_rel; $fell(reset_ctl_in) |-> ##[1:2] busy_init_out; endproperty
    a_rel: assert property (p_rel) else $error("no init");
    property p_diag; alarm_out |-> diag_code_out != 10'h000; endproperty
    a_diag: assert property (p_diag) else $error("diag empty");
    property p_l101; alarm_out && !$past(reset_ctl_in) && diag_code_out == 10'h065
        |-> actual_out == 10'h044; endproperty
    a_l101: assert property (p_l101) else $error("level 101");
    property p_l201; alarm_out && !$past(reset_ctl_in) && diag_code_out inside {[10'h0c9:10'h0cb]}
        |-> actual_out == 10'h155; endproperty
    a_l201: assert property (p_l201) else $error("level 201");
    property p_l304; alarm_out && !$past(reset_ctl_in) && diag_code_out == 10'h130
        |-> actual_out == 10'h199; endproperty
    a_l304: assert property (p_l304) else $error("level 304");
    property p_l9; alarm_out && !$past(reset_ctl_in)
        && diag_code_out inside {10'h385, [10'h391:10'h394]}
        |-> actual_out == 10'h1dd; endproperty
    a_l9: assert property (p_l9) else $error("level 9xx");
    // Full scale must never appear once start froze the alternation of code 302.
    property p_alt; alarm_out && !reset_ctl_in && !$past(reset_ctl_in)
        && diag_code_out == 10'h12e |-> actual_out == 10'h221; endproperty
    a_alt: assert property (p_alt) else $error("level not held");
    c_alarm: cover property (alarm_out);
    c_clear: cover property ($fell(reset_ctl_in));
    c_init: cover property (busy_init_out);
endmodule // fault_level_props
bind fault_code_level_indicator fault_level_props fault_level_props_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .reset_ctl_in(reset_ctl_in),
    .actual_out(actual_out), .alarm_out(alarm_out), .start_ok_out(start_ok_out),
    .busy_init_out(busy_init_out), .diag_code_out(diag_code_out));
`default_nettype wire

// [dv/plc_model.sv]
// Outside controller that pulses the clear input.
`timescale 1ns/1ps
`default_nettype none
module plc_model (
    input  wire logic clk_in,
    input  wire logic clear_req_in,
    output wire logic reset_ctl_out
);
    logic [2:0] hold_reg = 3'h0;
    // The clear is held four cycles, then released so the device can finish it.
    always @(posedge clk_in) begin
        if (clear_req_in) hold_reg <= 3'h4;
        else if (hold_reg != 3'h0) hold_reg <= hold_reg - 3'h1;
    end
    assign reset_ctl_out = hold_reg != 3'h0;
endmodule // plc_model
`default_nettype wire

// [dv/fault_code_level_indicator_tb.sv]
// Self-checking bench for the fault-level indicator.
`timescale 1ns/1ps
`default_nettype none
module fault_code_level_indicator_tb;
    logic       clk_in = 1'b0;
    logic       reset_n_in = 1'b0;
    logic       fault_valid_in = 1'b0;
    logic       start_in = 1'b0;
    logic       clk_en = 1'b1;
    logic       clear_req = 1'b0;
    logic       reset_ctl_in;
    logic [9:0] fault_code_in = 10'h000;
    logic [9:0] actual_out;
    logic [9:0] diag_code_out;
    logic       alarm_out;
    logic       start_ok_out;
    logic       busy_init_out;
    int         n_mismatch = 0;
    int         samples_checked = 0;
    // Each row: code, expected level, expected alarm.
    logic [20:0] rows [11] = '{{10'h065, 10'h044, 1'b1}, {10'h066, 10'h088, 1'b1},
        {10'h067, 10'h0cc, 1'b1}, {10'h06b, 10'h110, 1'b1}, {10'h0c9, 10'h155, 1'b1},
        {10'h0cb, 10'h155, 1'b1}, {10'h130, 10'h199, 1'b1}, {10'h385, 10'h1dd, 1'b1},
        {10'h394, 10'h1dd, 1'b1}, {10'h068, 10'h221, 1'b0}, {10'h0d3, 10'h221, 1'b0}};
    always #5 clk_in = ~clk_in;
    fault_code_level_indicator fault_code_level_indicator_inst (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .clk_en_in(clk_en), .temp_level_in(10'h123),
        .fault_valid_in(fault_valid_in), .fault_code_in(fault_code_in), .start_in(start_in),
        .reset_ctl_in(reset_ctl_in), .actual_out(actual_out), .alarm_out(alarm_out),
        .start_ok_out(start_ok_out), .busy_init_out(busy_init_out),
        .diag_code_out(diag_code_out));
    plc_model plc_model_inst (.clk_in(clk_in), .clear_req_in(clear_req),
        .reset_ctl_out(reset_ctl_in));
    task automatic check(input logic [9:0] seen, input logic [9:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic restart;
        reset_n_in = 1'b0;
        fault_valid_in = 1'b0;
        tick(8);
        reset_n_in = 1'b1;
        tick(3);
    endtask
    task automatic report_and_stop;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 11; i++) begin
            restart();
            check(actual_out, 10'h123);
            check({9'h000, start_ok_out}, 10'h001);
            fault_code_in = rows[i][20:11];
            fault_valid_in = 1'b1;
            tick(3);
            check(actual_out, rows[i][10:1]);
            check({9'h000, alarm_out}, {9'h000, rows[i][0]});
            check(diag_code_out, rows[i][20:11]);
        end
        restart();
        fault_code_in = 10'h12e;
        fault_valid_in = 1'b1;
        tick(3);
        clk_en = 1'b0;
        start_in = 1'b1;
        tick(2);
        check({9'h000, alarm_out}, 10'h000);
        clk_en = 1'b1;
        tick(2);
        check({9'h000, alarm_out}, 10'h001);
        check(actual_out, 10'h221);
        start_in = 1'b0;
        fault_code_in = 10'h065;
        tick(2);
        fault_valid_in = 1'b0;
        tick(2);
        check(diag_code_out, 10'h12e);
        check({9'h000, alarm_out}, 10'h001);
        clear_req = 1'b1;
        tick(1);
        clear_req = 1'b0;
        tick(3);
        check(actual_out, 10'h000);
        tick(4);
        check({9'h000, alarm_out}, 10'h000);
        check({9'h000, busy_init_out}, 10'h001);
        check({9'h000, start_ok_out}, 10'h000);
        report_and_stop();
    end
    // The whole sequence needs about 2 us; the limit leaves wide margin.
    initial begin
        #50000;
        n_mismatch++;
        report_and_stop();
    end
endmodule // fault_code_level_indicator_tb
`default_nettype wire
